// File: core/slt_pkg.sv
// slt_pkg: shared constants and types of the serial link sync/test control
// assumes: both link ends and the bench import this package
package slt_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned LANES  = 8;

    // ------------------------------------------------------------
    // device register map, reset values, writable bits
    // ------------------------------------------------------------
    localparam logic [9:0] ADDR_SOFT_SYNC = 10'h203;
    localparam logic [9:0] ADDR_CTRL      = 10'h204;
    localparam logic [9:0] ADDR_TEST      = 10'h205;
    localparam logic [7:0] SOFT_SYNC_RST  = 8'h01;
    localparam logic [7:0] CTRL_RST       = 8'h03;
    localparam logic [7:0] TEST_RST       = 8'h00;
    localparam logic [7:0] SOFT_SYNC_MASK = 8'h01;
    localparam logic [7:0] CTRL_MASK      = 8'h1f;
    localparam logic [7:0] TEST_MASK      = 8'h1f;

    // link_control field positions
    localparam int unsigned CTRL_SCR_BIT   = 0;
    localparam int unsigned CTRL_FMT_BIT   = 1;
    localparam int unsigned CTRL_SEL_LSB   = 2;
    localparam int unsigned CTRL_UPPER_BIT = 4;

    // sync source codes
    localparam logic [1:0] SYNC_SEL_SE   = 2'h0;
    localparam logic [1:0] SYNC_SEL_TS   = 2'h1;
    localparam logic [1:0] SYNC_SEL_SOFT = 2'h2;

    // lane mapping
    localparam logic [3:0] UPPER_MAX_LANES = 4'h4;

    // forced serial words
    localparam logic [15:0] WORD_LOW   = 16'h0000;
    localparam logic [15:0] WORD_HIGH  = 16'hffff;
    localparam logic [15:0] WORD_CLOCK = 16'h00ff;

    // test pattern codes
    typedef enum logic [4:0] {
        TP_NORMAL = 5'h00, TP_PRBS7 = 5'h01, TP_PRBS15 = 5'h02,
        TP_PRBS23 = 5'h03, TP_RAMP  = 5'h04, TP_TRANSPORT = 5'h05,
        TP_D21_5  = 5'h06, TP_K28_5 = 5'h07, TP_ILA_REPEAT = 5'h08,
        TP_RPAT   = 5'h09, TP_LOW   = 5'h0a, TP_HIGH = 5'h0b,
        TP_RSVD12 = 5'h0c, TP_PRBS9 = 5'h0d, TP_PRBS31 = 5'h0e,
        TP_CLOCK  = 5'h0f, TP_K28_7 = 5'h10
    } slt_test_type;

    // ------------------------------------------------------------
    // host own register map
    // ------------------------------------------------------------
    localparam logic [1:0] HOST_TARGET = 2'h0;
    localparam logic [1:0] HOST_WDATA  = 2'h1;
    localparam logic [1:0] HOST_CMD    = 2'h2;
    localparam logic [1:0] HOST_STATUS = 2'h3;
    localparam int unsigned CMD_WR_BIT  = 0;
    localparam int unsigned CMD_RD_BIT  = 1;
    localparam int unsigned ST_BUSY     = 0;
    localparam int unsigned ST_DONE     = 1;
    localparam int unsigned ST_REFUSED  = 2;
    localparam int unsigned ST_ADVISE   = 3;

    typedef enum logic [1:0] {
        HS_IDLE    = 2'b00,
        HS_STROBE  = 2'b01,
        HS_CAPTURE = 2'b10
    } slt_host_state_type;

endpackage : slt_pkg

// File: core/slt_link_if.sv
// slt_link_if: register access and mode status between host and device
// assumes: both ends run on the same core clock
`timescale 1ns/1ps
interface slt_link_if;
    // register access, host is master
    logic [9:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    // device mode status seen by host
    logic       link_enable;
    logic [3:0] lanes_per_link;
    logic       mode_64b66b;
    logic       ts_recv_enable;

    modport dev (
        input  reg_addr, reg_wdata, reg_wr, reg_rd,
        output reg_rdata, link_enable, lanes_per_link, mode_64b66b,
        output ts_recv_enable
    );
    modport host (
        output reg_addr, reg_wdata, reg_wr, reg_rd,
        input  reg_rdata, link_enable, lanes_per_link, mode_64b66b,
        input  ts_recv_enable
    );
endinterface : slt_link_if

// File: core/slt_dev.sv
// slt_dev: link sync, lane map, format, scrambler and test control regs
// assumes: host keeps reserved bits zero and writes only with link off;
// mode decode (lane count, encoding) comes from the link core
//
// Operation
// - soft sync bit low requests link sync
// - soft request works under any source select
// - software writes reserved fields as zero
// - lower mapping uses lanes 0 to L-1
// - upper mapping uses lanes 4 to 4+L-1
// - upper mapping only when L at most four
// - source field picks sync pin or none
// - timestamp receiver on before timestamp source
// - format bit: offset binary or two's complement
// - scrambler bit switches 8b/10b scrambler
// - 64b/66b modes always scramble
// - keep 8b/10b scrambler enabled, recommended
// - change registers only with link disabled
// - test codes 0,1,2,3,13,14: normal, PRBS
// - codes 4-7: ramp, transport, D21.5, K28.5
// - codes 8,9,16: ILA, RPAT, K28.7
// - code 10 lanes low, 11 high
// - code 15 sends 0x00FF clock pattern
// - never program reserved test codes
// - 8b/10b-only test codes need 8b/10b mode
// - link disabled: reset, power down, gate clocks
// - output mode selects config and encoding
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module slt_dev
    import slt_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    // link to host
    slt_link_if.dev               link,
    // mode inputs from link core
    input  wire logic             link_enable_i,
    input  wire logic [5:0]       link_output_mode_i,
    input  wire logic [3:0]       mode_lanes_i,
    input  wire logic             mode_64b66b_i,
    input  wire logic             timestamp_receiver_enable_i,
    // asynchronous sync pins, low asserts
    input  wire logic             single_ended_sync_pin_i,
    input  wire logic             timestamp_pin_pair_i,
    // controls to link core
    output logic                  link_sync_req_o,
    output logic [slt_pkg::LANES-1:0] lane_enable_o,
    output logic                  sample_twos_comp_o,
    output logic                  scrambler_on_o,
    output slt_pkg::slt_test_type test_pattern_o,
    output logic                  lane_force_o,
    output logic [15:0]           lane_force_word_o,
    output logic [5:0]            link_output_mode_o,
    output logic                  link_reset_o,
    output logic                  serdes_power_down_o,
    output logic                  link_clk_en_o
);
    import slt_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic               soft_sync_low;
        logic [4:0]         ctrl;
        logic [4:0]         test;
        logic [2:0]         se_sync;
        logic [2:0]         ts_sync;
        logic               se_level;
        logic               ts_level;
        logic [7:0]         rdata;
        logic               link_en;
        logic [3:0]         lanes;
        logic               m64;
        logic               ts_en;
        logic               sync_req;
        logic [LANES-1:0]   lane_en;
        logic               fmt;
        logic               scr_on;
        slt_test_type       tp;
        logic               force_en;
        logic [15:0]        force_word;
        logic [5:0]         mode;
        logic               link_rst;
        logic               pd;
        logic               clk_en;
    } slt_dev_state_type;

    localparam slt_dev_state_type DEV_RST = '{
        soft_sync_low: SOFT_SYNC_RST[0],
        ctrl:          CTRL_RST[4:0],
        test:          TEST_RST[4:0],
        se_sync:       3'h7,
        ts_sync:       3'h7,
        se_level:      1'b1,
        ts_level:      1'b1,
        fmt:           CTRL_RST[CTRL_FMT_BIT],
        scr_on:        CTRL_RST[CTRL_SCR_BIT],
        tp:            TP_NORMAL,
        link_rst:      1'b1,
        pd:            1'b1,
        default:       '0
    };

    slt_dev_state_type q;
    slt_dev_state_type d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // lane mask for L lanes, lower or upper group
    function automatic logic [LANES-1:0] lane_mask(
        input logic [3:0] l,
        input logic       upper
    );
        logic [15:0] m;
        m = (16'h0001 << l) - 16'h0001;
        if (upper)
        begin
            m = {m[11:0], 4'h0};
        end
        return m[LANES-1:0];
    endfunction : lane_mask

    // test code to pattern, unsupported codes fall back to normal
    function automatic slt_test_type test_decode(
        input logic [4:0] code,
        input logic       m64
    );
        slt_test_type t;
        t = TP_NORMAL;
        case (code)
            5'h00, 5'h01, 5'h02, 5'h03, 5'h0d, 5'h0e:
                t = slt_test_type'(code);
            5'h04, 5'h05, 5'h06:
                t = slt_test_type'(code);
            5'h07:
                t = m64 ? TP_NORMAL : TP_K28_5;
            5'h08, 5'h09, 5'h10:
                t = m64 ? TP_NORMAL : slt_test_type'(code);
            5'h0a, 5'h0b, 5'h0f:
                t = slt_test_type'(code);
            default:
                t = TP_NORMAL;
        endcase
        return t;
    endfunction : test_decode

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       pin_low;
        logic [1:0] sel;
        pin_low = 1'b0;
        sel     = 2'h0;
        d       = q;

        // three-stage pin synchronisers, level taken when the last two stages agree
        d.se_sync = {q.se_sync[1:0], single_ended_sync_pin_i};
        d.ts_sync = {q.ts_sync[1:0], timestamp_pin_pair_i};
        if (q.se_sync[1] == q.se_sync[2])
        begin
            d.se_level = q.se_sync[2];
        end
        if (q.ts_sync[1] == q.ts_sync[2])
        begin
            d.ts_level = q.ts_sync[2];
        end

        // register writes, reserved bits are not stored
        if (link.reg_wr)
        begin
            case (link.reg_addr)
                ADDR_SOFT_SYNC: d.soft_sync_low = link.reg_wdata[0];
                ADDR_CTRL:      d.ctrl = link.reg_wdata[4:0];
                ADDR_TEST:      d.test = link.reg_wdata[4:0];
                default:        d.soft_sync_low = q.soft_sync_low;
            endcase
        end

        // register reads, data stands the next cycle, unmapped reads zero
        d.rdata = 8'h00;
        if (link.reg_rd)
        begin
            case (link.reg_addr)
                ADDR_SOFT_SYNC: d.rdata = {7'h00, q.soft_sync_low};
                ADDR_CTRL:      d.rdata = {3'h0, q.ctrl};
                ADDR_TEST:      d.rdata = {3'h0, q.test};
                default:        d.rdata = 8'h00;
            endcase
        end

        // mode status mirrored to host, output mode passed on to link core
        d.link_en = link_enable_i;
        d.lanes   = mode_lanes_i;
        d.m64     = mode_64b66b_i;
        d.ts_en   = timestamp_receiver_enable_i;
        d.mode    = link_output_mode_i;

        // sync source; code 2 and the unused code 3 ignore every pin
        sel = q.ctrl[CTRL_SEL_LSB +: 2];
        case (sel)
            SYNC_SEL_SE: pin_low = ~q.se_level;
            SYNC_SEL_TS: pin_low = ~q.ts_level;
            default:     pin_low = 1'b0;
        endcase
        // soft request acts under any select
        d.sync_req = ~q.soft_sync_low | pin_low;

        // lane map, no lanes while link is off
        d.lane_en = '0;
        if (link_enable_i)
        begin
            if (q.ctrl[CTRL_UPPER_BIT])
            begin
                d.lane_en = lane_mask(mode_lanes_i, 1'b1);
            end
            else
            begin
                d.lane_en = lane_mask(mode_lanes_i, 1'b0);
            end
        end

        // sample format and scrambler
        d.fmt    = q.ctrl[CTRL_FMT_BIT];
        d.scr_on = q.ctrl[CTRL_SCR_BIT]
                 | mode_64b66b_i;

        // test pattern and forced serial word
        d.tp = test_decode(q.test, mode_64b66b_i);
        case (d.tp)
            TP_LOW:
            begin
                d.force_en   = 1'b1;
                d.force_word = WORD_LOW;
            end
            TP_HIGH:
            begin
                d.force_en   = 1'b1;
                d.force_word = WORD_HIGH;
            end
            TP_CLOCK:
            begin
                d.force_en   = 1'b1;
                d.force_word = WORD_CLOCK;
            end
            default:
            begin
                d.force_en   = 1'b0;
                d.force_word = WORD_LOW;
            end
        endcase

        // link held in reset, serdes down and clocks gated while off
        d.link_rst = ~link_enable_i;
        d.pd       = ~link_enable_i;
        d.clk_en   = link_enable_i;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= DEV_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // host side
    assign link.reg_rdata      = q.rdata;
    assign link.link_enable    = q.link_en;
    assign link.lanes_per_link = q.lanes;
    assign link.mode_64b66b    = q.m64;
    assign link.ts_recv_enable = q.ts_en;

    // link core side
    assign link_sync_req_o     = q.sync_req;
    assign lane_enable_o       = q.lane_en;
    assign sample_twos_comp_o  = q.fmt;
    assign scrambler_on_o      = q.scr_on;
    assign test_pattern_o      = q.tp;
    assign lane_force_o        = q.force_en;
    assign lane_force_word_o   = q.force_word;
    assign link_output_mode_o  = q.mode;
    assign link_reset_o        = q.link_rst;
    assign serdes_power_down_o = q.pd;
    assign link_clk_en_o       = q.clk_en;

endmodule : slt_dev

// File: core/slt_host.sv
// slt_host: controller that programs the device link registers
// assumes: software drives the plain command port; device answers
// reads one cycle after the read strobe
`timescale 1ns/1ps
module slt_host
    import slt_pkg::*;
(
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_b_i,
    // link to device
    slt_link_if.host          link,
    // software port
    input  wire logic [1:0]   usr_addr_i,
    input  wire logic [15:0]  usr_wdata_i,
    input  wire logic         usr_wr_i,
    input  wire logic         usr_rd_i,
    output logic [15:0]       usr_rdata_o
);
    import slt_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        slt_host_state_type st;
        logic [9:0]         target;
        logic [7:0]         wdata;
        logic               is_rd;
        logic               done;
        logic               refused;
        logic               advise;
        logic [7:0]         rdval;
        logic [9:0]         bus_addr;
        logic [7:0]         bus_wdata;
        logic               bus_wr;
        logic               bus_rd;
        logic [15:0]        usr_rdata;
    } slt_host_state_reg_type;

    localparam slt_host_state_reg_type HOST_RST = '{
        st:      HS_IDLE,
        default: '0
    };

    slt_host_state_reg_type q;
    slt_host_state_reg_type d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       refuse;
        logic [7:0] wval;
        logic [4:0] code;
        refuse = 1'b0;
        wval   = q.wdata;
        code   = q.wdata[4:0];
        d      = q;
        d.bus_wr    = 1'b0;
        d.bus_rd    = 1'b0;
        d.usr_rdata = 16'h0000;

        // software reads, data stands the next cycle
        if (usr_rd_i)
        begin
            case (usr_addr_i)
                HOST_TARGET: d.usr_rdata = {6'h00, q.target};
                HOST_WDATA:  d.usr_rdata = {8'h00, q.wdata};
                HOST_STATUS: d.usr_rdata = {q.rdval, 4'h0, q.advise,
                                            q.refused, q.done,
                                            q.st != HS_IDLE};
                default:     d.usr_rdata = 16'h0000;
            endcase
        end

        // software writes; status bits clear on write of one
        if (usr_wr_i)
        begin
            case (usr_addr_i)
                HOST_TARGET: d.target = usr_wdata_i[9:0];
                HOST_WDATA:  d.wdata  = usr_wdata_i[7:0];
                HOST_STATUS:
                begin
                    d.done    = q.done    & ~usr_wdata_i[ST_DONE];
                    d.refused = q.refused & ~usr_wdata_i[ST_REFUSED];
                    d.advise  = q.advise  & ~usr_wdata_i[ST_ADVISE];
                end
                default:     d.target = q.target;
            endcase
        end

        // checks on a write to the link registers
        case (q.target)
            ADDR_SOFT_SYNC: wval = q.wdata & SOFT_SYNC_MASK;
            ADDR_CTRL:
            begin
                wval   = q.wdata & CTRL_MASK;
                refuse = link.link_enable
                       | (q.wdata[CTRL_SEL_LSB +: 2] == 2'h3)
                       | (q.wdata[CTRL_UPPER_BIT]
                          & (link.lanes_per_link > UPPER_MAX_LANES))
                       | ((q.wdata[CTRL_SEL_LSB +: 2] == SYNC_SEL_TS)
                          & ~link.ts_recv_enable);
            end
            ADDR_TEST:
            begin
                wval   = q.wdata & TEST_MASK;
                refuse = link.link_enable
                       | (code == TP_RSVD12)
                       | (code > TP_K28_7)
                       | (link.mode_64b66b
                          & ((code == TP_K28_5) | (code == TP_ILA_REPEAT)
                             | (code == TP_RPAT)
                             | (code == TP_K28_7)));
            end
            default:        wval = q.wdata;
        endcase

        // command sequencer
        case (q.st)
            HS_IDLE:
            begin
                if (usr_wr_i && usr_addr_i == HOST_CMD
                    && usr_wdata_i[CMD_WR_BIT])
                begin
                    if (refuse)
                    begin
                        d.refused = 1'b1;
                    end
                    else
                    begin
                        d.bus_addr  = q.target;
                        d.bus_wdata = wval;
                        d.bus_wr    = 1'b1;
                        d.is_rd     = 1'b0;
                        d.st        = HS_STROBE;
                        // scrambler off in 8b/10b noted as advisory
                        if (q.target == ADDR_CTRL && !q.wdata[CTRL_SCR_BIT]
                            && !link.mode_64b66b)
                        begin
                            d.advise = 1'b1;
                        end
                    end
                end
                else if (usr_wr_i && usr_addr_i == HOST_CMD
                         && usr_wdata_i[CMD_RD_BIT])
                begin
                    d.bus_addr = q.target;
                    d.bus_rd   = 1'b1;
                    d.is_rd    = 1'b1;
                    d.st       = HS_STROBE;
                end
            end
            HS_STROBE:
            begin
                d.st = q.is_rd ? HS_CAPTURE : HS_IDLE;
                if (!q.is_rd)
                begin
                    d.done = 1'b1;
                end
            end
            HS_CAPTURE:
            begin
                d.rdval = link.reg_rdata;
                d.done  = 1'b1;
                d.st    = HS_IDLE;
            end
            default:
            begin
                d.st = HS_IDLE;
            end
        endcase

        // command while busy is refused
        if (q.st != HS_IDLE && usr_wr_i && usr_addr_i == HOST_CMD
            && (usr_wdata_i[CMD_WR_BIT] || usr_wdata_i[CMD_RD_BIT]))
        begin
            d.refused = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= HOST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.reg_addr  = q.bus_addr;
    assign link.reg_wdata = q.bus_wdata;
    assign link.reg_wr    = q.bus_wr;
    assign link.reg_rd    = q.bus_rd;
    assign usr_rdata_o    = q.usr_rdata;

endmodule : slt_host

// File: verification/slt_monitor.sv
// slt_monitor: checks on register writes crossing the link
// assumes: sits beside slt_link_if, one clock domain
`timescale 1ns/1ps
module slt_monitor
    import slt_pkg::*;
(
    // clock, reset and link signals
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic link_enable,
    input wire logic [3:0] lanes_per_link,
    input wire logic mode_64b66b,
    input wire logic ts_recv_enable
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    // writes to control and test registers
    wire logic wc = reg_wr && reg_addr == ADDR_CTRL;
    wire logic wt = reg_wr && reg_addr == ADDR_TEST;
    wire logic [4:0] cd = reg_wdata[4:0];
    // only legal contents may reach the device
    AST_SOFT_RSVD: assert property (reg_wr && reg_addr == ADDR_SOFT_SYNC |-> reg_wdata[7:1] == 7'h00)
        else $error("sync reserved bits");
    AST_RSVD: assert property (wc || wt |-> reg_wdata[7:5] == 3'h0)
        else $error("reserved bits");
    AST_LINK_OFF: assert property (wc || wt |-> !link_enable)
        else $error("write with link on");
    AST_SEL: assert property (wc |-> reg_wdata[3:2] != 2'h3)
        else $error("bad sync source");
    AST_UPPER: assert property (wc && reg_wdata[4] |-> lanes_per_link <= UPPER_MAX_LANES)
        else $error("upper map too wide");
    AST_TS: assert property (wc && reg_wdata[3:2] == SYNC_SEL_TS |-> ts_recv_enable)
        else $error("timestamp receiver off");
    AST_CODE: assert property (wt |-> cd != 5'h0c && cd <= 5'h10)
        else $error("reserved test code");
    AST_CODE_8B: assert property (wt && mode_64b66b |-> !(cd inside {5'h07, 5'h08, 5'h09, 5'h10}))
        else $error("8b/10b code in 64b/66b");
endmodule : slt_monitor

// File: verification/testbench.sv
// testbench: host and device joined by the link, software port driven
// assumes: core files compiled first
`timescale 1ns/1ps
`define CHK(a,b) begin total_checks++; if ((a)!==(b)) begin miscompares++; $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module testbench;
    import slt_pkg::*;
    logic clk = 0, rst_b = 0, uwr = 0, urd = 0, len = 0, m64 = 0, tse = 1, sep = 1, tsp = 1;
    logic sreq, fmt, scrambler_enable, frc, lrst, pdn, cken;
    logic [1:0] ua = 0;
    logic [3:0] nl = 4;
    logic [5:0] md = 0, mdo;
    logic [7:0] ln, c, f;
    logic [15:0] uwd = 0, urdat, fw, s;
    slt_test_type tp;
    int miscompares = 0, total_checks = 0;
    slt_link_if lk();
    // the two ends and the checker
    slt_host i_slt_host (.core_clk_i(clk), .rst_b_i(rst_b), .link(lk), .usr_addr_i(ua), .usr_wdata_i(uwd),
        .usr_wr_i(uwr), .usr_rd_i(urd), .usr_rdata_o(urdat));
    slt_dev i_slt_dev (.core_clk_i(clk), .rst_b_i(rst_b), .link(lk), .link_enable_i(len), .link_output_mode_i(md),
        .mode_lanes_i(nl), .mode_64b66b_i(m64), .timestamp_receiver_enable_i(tse), .single_ended_sync_pin_i(sep),
        .timestamp_pin_pair_i(tsp), .link_sync_req_o(sreq), .lane_enable_o(ln), .sample_twos_comp_o(fmt),
        .scrambler_on_o(scrambler_enable), .test_pattern_o(tp), .lane_force_o(frc), .lane_force_word_o(fw),
        .link_output_mode_o(mdo), .link_reset_o(lrst), .serdes_power_down_o(pdn), .link_clk_en_o(cken));
    slt_monitor i_slt_monitor (.core_clk_i(clk), .rst_b_i(rst_b), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
        .reg_wr(lk.reg_wr), .link_enable(lk.link_enable), .lanes_per_link(lk.lanes_per_link),
        .mode_64b66b(lk.mode_64b66b), .ts_recv_enable(lk.ts_recv_enable));
    // expected sync request and lane mask
    function automatic logic exp_req(logic [7:0] a, logic sf, logic se, logic ts);
        return !sf || (a[3:2] == SYNC_SEL_SE && !se) || (a[3:2] == SYNC_SEL_TS && !ts);
    endfunction : exp_req
    function automatic logic [7:0] exp_lanes(logic [3:0] l, logic u);
        return (8'hff >> (8 - l)) << (u ? 4 : 0);
    endfunction : exp_lanes
    // one software port cycle, read data kept in s
    task bus(input logic [1:0] a, input logic [15:0] d, input logic r);
        @(posedge clk);
        ua <= a; uwd <= d; uwr <= !r; urd <= r;
        @(posedge clk);
        uwr <= 0; urd <= 0;
        #1 s = urdat;
    endtask : bus
    // clear flags, run one device access, read status
    task op(input logic [9:0] t, input logic [7:0] d, input logic [1:0] k);
        bus(HOST_STATUS, 16'h000e, 0);
        bus(HOST_TARGET, 16'(t), 0);
        bus(HOST_WDATA, 16'(d), 0);
        bus(HOST_CMD, 16'(k), 0);
        repeat (4) @(posedge clk);
        bus(HOST_STATUS, 0, 1);
    endtask : op
    task settle;
        repeat (8) @(posedge clk);
        #1;
    endtask : settle
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    // clock and watchdog
    initial forever #20 clk = ~clk;
    initial
    begin
        #400000 miscompares++;
        print_verdict;
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h1e8d));
        repeat (6) @(posedge clk);
        rst_b <= 1;
        op(ADDR_SOFT_SYNC, 0, 2); `CHK(s[15:8], SOFT_SYNC_RST)
        op(ADDR_CTRL, 0, 2); `CHK(s[15:8], CTRL_RST)
        op(ADDR_TEST, 0, 2); `CHK(s[15:8], TEST_RST)
        `CHK({sreq, scrambler_enable, fmt, lrst, pdn, cken}, 6'h1e)
        repeat (30)
        begin
            c = {4'h0, 2'($urandom % 3), 2'($urandom)};
            f = 8'($urandom);
            op(ADDR_CTRL, c, 1);
            `CHK(s[3:1], {!c[0] && !m64, 2'b01})
            op(ADDR_SOFT_SYNC, f, 1);
            sep <= 1'($urandom); tsp <= 1'($urandom); m64 <= 1'($urandom);
            md <= 6'($urandom);
            settle;
            `CHK(sreq, exp_req(c, f[0], sep, tsp))
            `CHK({fmt, scrambler_enable}, {c[1], c[0] | m64})
            `CHK(mdo, md)
            `CHK(ln, 8'h00)
        end
        for (int u = 0; u < 2; u++)
        begin
            nl <= 4'(1 + $urandom % (u ? 4 : 8));
            op(ADDR_CTRL, {3'h0, u[0], 4'h3}, 1);
            len <= 1;
            settle;
            `CHK(ln, exp_lanes(nl, u[0]))
            `CHK({lrst, pdn, cken}, 3'h1)
            op(ADDR_TEST, 8'h05, 1); `CHK(s[2], 1'b1)
            len <= 0;
        end
        m64 <= 0;
        for (int k = 0; k < 17; k++)
        begin
            op(ADDR_TEST, 8'(k), 1);
            settle;
            // code 12 is refused, so code 11 stays in force
            `CHK(s[2], 1'(k == 12))
            `CHK(tp, slt_test_type'(k == 12 ? 11 : k))
            `CHK(frc, 1'(k inside {10, 11, 12, 15}))
            `CHK(fw, k inside {11, 12} ? WORD_HIGH : k == 15 ? WORD_CLOCK : WORD_LOW)
        end
        m64 <= 1; tse <= 0; nl <= 8;
        settle;
        `CHK(tp, TP_NORMAL)
        op(ADDR_TEST, 8'h0e, 1);
        `CHK(tp, TP_PRBS31)
        op(ADDR_CTRL, 8'h13, 1); `CHK(s[2], 1'b1)
        op(ADDR_TEST, 8'h10, 1); `CHK(s[2], 1'b1)
        op(ADDR_CTRL, 8'h07, 1); `CHK(s[2], 1'b1)
        op(ADDR_CTRL, 8'h0f, 1); `CHK(s[2], 1'b1)
        print_verdict;
    end
endmodule : testbench
